// [verilog/ilc_pkg.sv]
// Constants for the in-band link and low power idle control block.
// Assumes a 16-bit paged management register port on the PHY side.
`default_nettype none
package ilc_pkg;
  // Clock rate in MHz
  localparam int CLK_MHZ = 40;
  // Pages and register numbers
  localparam logic [9:0] PAGE_LINK      = 10'h302;
  localparam logic [9:0] PAGE_IDLE      = 10'h304;
  localparam logic [4:0] ADDR_PWR_MGMT  = 5'h11;
  localparam logic [4:0] ADDR_MSG_CTRL  = 5'h12;
  localparam logic [4:0] ADDR_ACK_TMO   = 5'h14;
  localparam logic [4:0] ADDR_EXIT_TMO  = 5'h15;
  localparam logic [4:0] ADDR_EI_MIN    = 5'h17;
  localparam logic [4:0] ADDR_GPIO_CTRL = 5'h12;
  localparam logic [4:0] ADDR_IDLE_CTRL = 5'h14;
  // Reset values
  localparam logic [15:0] RST_PWR_MGMT  = 16'h0000;
  localparam logic [15:0] RST_MSG_CTRL  = 16'h0507;
  localparam logic [15:0] RST_ACK_TMO   = 16'h5504;
  localparam logic [15:0] RST_EXIT_TMO  = 16'h0514;
  localparam logic [15:0] RST_EI_MIN    = 16'h0010;
  localparam logic [15:0] RST_GPIO_CTRL = 16'h00c9;
  localparam logic [15:0] RST_IDLE_CTRL = 16'h0220;
  // Writable bits
  localparam logic [15:0] WMASK_PWR_MGMT  = 16'h4000;
  localparam logic [15:0] WMASK_IDLE_CTRL = 16'hfff0;
  // Field positions
  localparam int MSG_PERIOD_LSB  = 8;
  localparam int MSG_PAD_DIS_BIT = 7;
  localparam int MSG_RETRY_LSB   = 0;
  localparam int ACK_MDIO_LSB    = 8;
  localparam int ACK_STAT_LSB    = 0;
  localparam int EXIT_LSB        = 6;
  localparam int EI_LSB          = 0;
  localparam int GPIO_AUTO_BIT   = 11;
  localparam int GPIO_ROUTE_BIT  = 10;
  localparam int IDLE_GIG_BIT    = 14;
  localparam int IDLE_FAST_BIT   = 13;
  localparam int IDLE_FORCE_BIT  = 12;
  localparam int IDLE_POST_LSB   = 9;
  localparam int IDLE_PLL_LSB    = 4;
  localparam int PWR_LPS_EN_BIT  = 14;
  // Timing units
  localparam int UNIT_NS         = 80;
  localparam int STATUS_UNIT_US  = 10;
  localparam int POST_UNIT_US    = 8;
  localparam int SMBUS_SCALE     = 1000;
  // Link speed codes
  localparam logic [1:0] SPEED_10   = 2'h0;
  localparam logic [1:0] SPEED_100  = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;
endpackage
`default_nettype wire

// [verilog/ilc_inband_lpi.sv]
// In-band message timing and energy-efficient idle control.
// Assumes synchronous inputs on clk and a one-cycle register port.
`timescale 1ns/1ps
`default_nettype none
module ilc_inband_lpi #(
  parameter int CLK_MHZ = ilc_pkg::CLK_MHZ
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        pwrGoodRst,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [9:0]  regPage,
  input  wire logic [4:0]  regAddr,
  input  wire logic [15:0] regWdata,
  output logic      [15:0] regRdata,
  output logic             regRdValid,
  input  wire logic        smbusMode,
  input  wire logic        linkUp,
  input  wire logic [1:0]  linkSpeed,
  input  wire logic        linkLowPowerState,
  input  wire logic        mdioMsgReq,
  input  wire logic        msgAck,
  output logic             msgSend,
  output logic             msgIsMdio,
  output logic             msgFail,
  output logic             gigMsgInPacketOk,
  input  wire logic        lowPowerExit,
  output logic             txDataHold,
  input  wire logic        elecIdleReq,
  output logic             elecIdle,
  input  wire logic        ctrlTxReq,
  output logic             txRelease,
  output logic             txIdleInd,
  output logic             gpio0Out,
  output logic             pllLockForce,
  output logic      [2:0]  pllLockCode,
  output logic             lpsEnable
);
  localparam int UNIT_CYC = (ilc_pkg::UNIT_NS * CLK_MHZ + 999) / 1000;

  // Rate check at elaboration; the 6-bit tick divider caps the rate
  if (CLK_MHZ < 1 || CLK_MHZ > 64) begin : gBadClk
    $error("CLK_MHZ outside 1..64");
  end

  typedef enum logic [1:0] {
    MSG_IDLE = 2'b01,
    MSG_WAIT = 2'b10
  } ilc_msg_state_t;

  // Paged register decode, shared by writes and reads
  function automatic logic regHit(input logic [9:0] p, input logic [4:0] a);
    regHit = (regPage == p) && (regAddr == a);
  endfunction

  // Timeout scaling for the sideband management mode
  function automatic logic [19:0] scaleTmo(input logic [19:0] v);
    scaleTmo = smbusMode ? 20'(v * 20'(ilc_pkg::SMBUS_SCALE)) : v;
  endfunction

  logic        pgRst;
  logic [15:0] regPwr;
  logic [15:0] regMsg;
  logic [15:0] regAck;
  logic [15:0] regExit;
  logic [15:0] regEi;
  logic [15:0] regGpio;
  logic [15:0] regIdle;
  logic        linkUpD;
  logic        linkRise;
  logic        linkFall;
  logic [5:0]  usDiv;
  logic        usTick;
  logic [19:0] statusCnt;
  logic [19:0] statusPeriod;
  logic        statusPend;
  logic        mdioPend;
  logic        takeMdio;
  logic        takeStatus;
  ilc_msg_state_t msgState;
  logic [6:0]  retryCnt;
  logic [19:0] ackTimer;
  logic [19:0] mdioTmo;
  logic [19:0] statTmo;
  logic [19:0] exitTimer;
  logic [19:0] eiTimer;
  logic [19:0] postTimer;
  logic        postBusy;
  logic        speedOk;

  // System reset covers all but the pin control; power-good reset covers everything
  assign pgRst    = sys_rst || pwrGoodRst;
  assign linkRise = linkUp && !linkUpD;
  assign linkFall = !linkUp && linkUpD;

  // Link edge detect
  always_ff @(posedge clk) begin
    if (pgRst) begin
      linkUpD <= 1'b0;
    end else begin
      linkUpD <= linkUp;
    end
  end

  // Link control registers on the first page
  always_ff @(posedge clk) begin
    if (pgRst) begin
      regMsg  <= ilc_pkg::RST_MSG_CTRL;
      regAck  <= ilc_pkg::RST_ACK_TMO;
      regExit <= ilc_pkg::RST_EXIT_TMO;
      regEi   <= ilc_pkg::RST_EI_MIN;
    end else if (regWr) begin
      if (regHit(ilc_pkg::PAGE_LINK, ilc_pkg::ADDR_MSG_CTRL)) begin
        regMsg <= regWdata;
      end
      if (regHit(ilc_pkg::PAGE_LINK, ilc_pkg::ADDR_ACK_TMO)) begin
        regAck <= regWdata;
      end
      if (regHit(ilc_pkg::PAGE_LINK, ilc_pkg::ADDR_EXIT_TMO)) begin
        regExit <= regWdata;
      end
      if (regHit(ilc_pkg::PAGE_LINK, ilc_pkg::ADDR_EI_MIN)) begin
        regEi <= regWdata;
      end
    end
  end

  // Low-power state enable; mode clear wins over a write
  always_ff @(posedge clk) begin
    if (pgRst) begin
      regPwr <= ilc_pkg::RST_PWR_MGMT;
    end else begin
      if (regWr && regHit(ilc_pkg::PAGE_LINK, ilc_pkg::ADDR_PWR_MGMT)) begin
        regPwr <= regWdata & ilc_pkg::WMASK_PWR_MGMT;
      end
      if (smbusMode) begin
        regPwr[ilc_pkg::PWR_LPS_EN_BIT] <= 1'b0;
      end
    end
  end
  assign lpsEnable = regPwr[ilc_pkg::PWR_LPS_EN_BIT];

  // Pin control kept across ordinary resets
  always_ff @(posedge clk) begin
    if (pwrGoodRst) begin
      regGpio <= ilc_pkg::RST_GPIO_CTRL;
    end else if (regWr && regHit(ilc_pkg::PAGE_IDLE,
                                 ilc_pkg::ADDR_GPIO_CTRL)) begin
      regGpio <= regWdata;
    end
  end

  // Idle control; hardware updates override a same-cycle write
  always_ff @(posedge clk) begin
    if (pgRst) begin
      regIdle <= ilc_pkg::RST_IDLE_CTRL;
    end else begin
      if (regWr && regHit(ilc_pkg::PAGE_IDLE, ilc_pkg::ADDR_IDLE_CTRL)) begin
        regIdle <= regWdata & ilc_pkg::WMASK_IDLE_CTRL;
      end
      if (linkFall) begin
        regIdle[ilc_pkg::IDLE_GIG_BIT]  <= 1'b0;
        regIdle[ilc_pkg::IDLE_FAST_BIT] <= 1'b0;
      end else if (linkRise && regGpio[ilc_pkg::GPIO_AUTO_BIT]) begin
        regIdle[ilc_pkg::IDLE_GIG_BIT]  <= 1'b1;
        regIdle[ilc_pkg::IDLE_FAST_BIT] <= 1'b1;
      end
    end
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (pgRst) begin
      regRdata   <= 16'h0000;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRd;
      if (regRd) begin
        if (regHit(ilc_pkg::PAGE_LINK, ilc_pkg::ADDR_PWR_MGMT)) begin
          regRdata <= regPwr;
        end else if (regHit(ilc_pkg::PAGE_LINK, ilc_pkg::ADDR_MSG_CTRL)) begin
          regRdata <= regMsg;
        end else if (regHit(ilc_pkg::PAGE_LINK, ilc_pkg::ADDR_ACK_TMO)) begin
          regRdata <= regAck;
        end else if (regHit(ilc_pkg::PAGE_LINK, ilc_pkg::ADDR_EXIT_TMO)) begin
          regRdata <= regExit;
        end else if (regHit(ilc_pkg::PAGE_LINK, ilc_pkg::ADDR_EI_MIN)) begin
          regRdata <= regEi;
        end else if (regHit(ilc_pkg::PAGE_IDLE,
                            ilc_pkg::ADDR_GPIO_CTRL)) begin
          regRdata <= regGpio;
        end else if (regHit(ilc_pkg::PAGE_IDLE,
                            ilc_pkg::ADDR_IDLE_CTRL)) begin
          regRdata <= regIdle;
        end else begin
          regRdata <= 16'h0000;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (pgRst) begin
      usDiv  <= 6'h00;
      usTick <= 1'b0;
    end else begin
      usTick <= (usDiv == 6'(CLK_MHZ - 1));
      usDiv  <= (usDiv == 6'(CLK_MHZ - 1)) ? 6'h00 : usDiv + 6'h01;
    end
  end

  assign statusPeriod = scaleTmo(20'(regMsg[ilc_pkg::MSG_PERIOD_LSB +: 6]
                                     * ilc_pkg::STATUS_UNIT_US));
  assign mdioTmo = scaleTmo(20'(regAck[ilc_pkg::ACK_MDIO_LSB +: 8]));
  assign statTmo = scaleTmo(20'(regAck[ilc_pkg::ACK_STAT_LSB +: 6]));

  always_ff @(posedge clk) begin
    if (pgRst) begin
      statusCnt  <= 20'h00000;
      statusPend <= 1'b0;
    end else begin
      if (takeStatus) begin
        statusPend <= 1'b0;
      end
      if (usTick) begin
        if (statusCnt + 20'h00001 >= statusPeriod) begin
          statusCnt  <= 20'h00000;
          statusPend <= 1'b1;  // Set wins over take
        end else begin
          statusCnt <= statusCnt + 20'h00001;
        end
      end
    end
  end

  // Pending management message; a new request wins over the take
  always_ff @(posedge clk) begin
    if (pgRst) begin
      mdioPend <= 1'b0;
    end else if (mdioMsgReq) begin
      mdioPend <= 1'b1;
    end else if (takeMdio) begin
      mdioPend <= 1'b0;
    end
  end

  // Management messages go first; status is repeated anyway
  assign takeMdio   = (msgState == MSG_IDLE) && mdioPend;
  assign takeStatus = (msgState == MSG_IDLE) && !mdioPend && statusPend;

  // Send, acknowledge wait and retry sequencer
  always_ff @(posedge clk) begin
    if (pgRst) begin
      msgState  <= MSG_IDLE;
      msgSend   <= 1'b0;
      msgIsMdio <= 1'b0;
      msgFail   <= 1'b0;
      retryCnt  <= 7'h00;
      ackTimer  <= 20'h00000;
    end else begin
      msgSend <= 1'b0;
      msgFail <= 1'b0;
      unique case (msgState)
        MSG_IDLE: begin
          if (takeMdio || takeStatus) begin
            msgSend   <= 1'b1;
            msgIsMdio <= takeMdio;
            retryCnt  <= 7'h00;
            ackTimer  <= takeMdio ? mdioTmo : statTmo;
            msgState  <= MSG_WAIT;
          end
        end
        MSG_WAIT: begin
          if (msgAck) begin
            msgState <= MSG_IDLE;
          end else if (usTick) begin
            if (ackTimer != 20'h00000) begin
              ackTimer <= ackTimer - 20'h00001;
            end else if (retryCnt < regMsg[ilc_pkg::MSG_RETRY_LSB +: 7]) begin
              msgSend  <= 1'b1;
              retryCnt <= retryCnt + 7'h01;
              ackTimer <= msgIsMdio ? mdioTmo : statTmo;
            end else begin
              msgFail  <= 1'b1;
              msgState <= MSG_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign gigMsgInPacketOk = !(regMsg[ilc_pkg::MSG_PAD_DIS_BIT] &&
                              (linkSpeed == ilc_pkg::SPEED_10 ||
                               linkSpeed == ilc_pkg::SPEED_100));

  always_ff @(posedge clk) begin
    if (pgRst) begin
      txDataHold <= 1'b0;
      exitTimer  <= 20'h00000;
    end else if (lowPowerExit) begin
      txDataHold <= 1'b1;
      exitTimer  <= 20'(scaleTmo(20'(regExit[ilc_pkg::EXIT_LSB +: 6]))
                        * 20'(UNIT_CYC));
    end else if (exitTimer != 20'h00000) begin
      exitTimer <= exitTimer - 20'h00001;
    end else begin
      txDataHold <= 1'b0;
    end
  end

  // Minimum electrical idle; request drop ignored until served
  always_ff @(posedge clk) begin
    if (pgRst) begin
      elecIdle <= 1'b0;
      eiTimer  <= 20'h00000;
    end else if (!elecIdle) begin
      if (elecIdleReq) begin
        elecIdle <= 1'b1;
        eiTimer  <= 20'(scaleTmo(20'(regEi[ilc_pkg::EI_LSB +: 5]))
                        * 20'(UNIT_CYC));
      end
    end else if (eiTimer != 20'h00000) begin
      eiTimer <= eiTimer - 20'h00001;
    end else if (!elecIdleReq) begin
      elecIdle <= 1'b0;
    end
  end

  // Speed enable matching the current link speed
  assign speedOk =
    (regIdle[ilc_pkg::IDLE_GIG_BIT] && linkSpeed == ilc_pkg::SPEED_1000) ||
    (regIdle[ilc_pkg::IDLE_FAST_BIT] && linkSpeed == ilc_pkg::SPEED_100);

  // Forced entry or enabled low-power state
  assign txIdleInd = regIdle[ilc_pkg::IDLE_FORCE_BIT] ||
                     (linkLowPowerState && speedOk);
  assign gpio0Out = regGpio[ilc_pkg::GPIO_ROUTE_BIT] && txIdleInd;

  assign pllLockForce = regIdle[ilc_pkg::IDLE_GIG_BIT] ||
                        regIdle[ilc_pkg::IDLE_FAST_BIT];
  assign pllLockCode  = regIdle[ilc_pkg::IDLE_PLL_LSB +: 3];

  // Post-idle delay; outside idle traffic is released at once
  always_ff @(posedge clk) begin
    if (pgRst) begin
      postBusy  <= 1'b0;
      postTimer <= 20'h00000;
      txRelease <= 1'b0;
    end else begin
      txRelease <= 1'b0;
      if (!postBusy && ctrlTxReq) begin
        if (txIdleInd) begin
          postBusy  <= 1'b1;
          postTimer <= 20'((regIdle[ilc_pkg::IDLE_POST_LSB +: 3] + 4'h1)
                           * ilc_pkg::POST_UNIT_US);
        end else begin
          txRelease <= 1'b1;
        end
      end else if (postBusy && usTick) begin
        if (postTimer > 20'h00001) begin
          postTimer <= postTimer - 20'h00001;
        end else begin
          postBusy  <= 1'b0;
          txRelease <= 1'b1;
        end
      end
    end
  end

endmodule // ilc_inband_lpi
`default_nettype wire

// [dv/ilc_ctrl_model.sv]
// Controller-side model that acknowledges in-band messages.
// Assumes msgSend is a one-cycle pulse sampled on the rising clk edge.
`timescale 1ns/1ps
`default_nettype none
module ilc_ctrl_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] ackMode,
  input  wire logic       msgSend,
  output logic            msgAck
);
  logic [5:0] delay;
  logic       busy;

  // Ack 3 or 21 cycles after msgSend is sampled; mode 2 never answers, forcing retries
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
      delay <= 6'h00;
      msgAck <= 1'b0;
    end else if (msgSend && ackMode != 2'h2) begin
      busy <= 1'b1;
      delay <= (ackMode == 2'h0) ? 6'h02 : 6'h14;
      msgAck <= 1'b0;
    end else if (busy && delay == 6'h00) begin
      busy <= 1'b0;
      msgAck <= 1'b1;
    end else begin
      delay <= delay - 6'h01;  // Wraps when idle, harmless
      msgAck <= 1'b0;
    end
  end
endmodule // ilc_ctrl_model
`default_nettype wire

// [dv/ilc_inband_lpi_assertions.sv]
// Assertion checker for the in-band link and idle control block.
// Bound to ilc_inband_lpi; sees its ports only, resets held 2+ cycles.
`timescale 1ns/1ps
`default_nettype none
module ilc_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       pwrGoodRst,
  input wire logic       regRd,
  input wire logic       regWr,
  input wire logic       regRdValid,
  input wire logic [1:0] linkSpeed,
  input wire logic       linkUp,
  input wire logic       smbusMode,
  input wire logic       lowPowerExit,
  input wire logic       elecIdleReq,
  input wire logic       ctrlTxReq,
  input wire logic       gigMsgInPacketOk,
  input wire logic       txDataHold,
  input wire logic       elecIdle,
  input wire logic       txRelease,
  input wire logic       txIdleInd,
  input wire logic       gpio0Out,
  input wire logic       pllLockForce,
  input wire logic [2:0] pllLockCode,
  input wire logic       lpsEnable,
  input wire logic       msgFail
);
  logic [15:0] holdCnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || pwrGoodRst);

  // Length of the current idle-symbol hold, too long to unroll
  always_ff @(posedge clk) begin
    if (sys_rst || pwrGoodRst || !txDataHold) begin
      holdCnt <= 16'h0000;
    end else begin
      holdCnt <= holdCnt + 16'h0001;
    end
  end

  rd_answer_a: assert property (regRd |=> regRdValid)
    else $error("read not answered");
  pad_gig_a: assert property (linkSpeed == 2'h2 |-> gigMsgInPacketOk)
    else $error("gigabit messages blocked at 1000");
  exit_cause_a: assert property ($rose(txDataHold) |->
    $past(lowPowerExit) || $past(lowPowerExit, 2))
    else $error("idle hold without exit");
  exit_bound_a: assert property (!smbusMode |-> holdCnt <= 16'h0100)
    else $error("idle hold too long");
  eidle_cause_a: assert property ($rose(elecIdle) |->
    $past(elecIdleReq) || $past(elecIdleReq, 2))
    else $error("electrical idle without request");
  eidle_leave_a: assert property ($fell(elecIdle) |->
    !$past(elecIdleReq))
    else $error("left electrical idle while requested");
  route_gpio_a: assert property (gpio0Out |-> txIdleInd)
    else $error("pin zero high without idle");
  link_down_a: assert property ($fell(linkUp) |->
    ##[1:3] !pllLockForce)
    else $error("speed enables kept after link down");
  post_wait_a: assert property (ctrlTxReq && txIdleInd |=>
    !txRelease [*8])
    else $error("release before post-idle wait");
  post_skip_a: assert property (ctrlTxReq && !txIdleInd |->
    ##[1:2] txRelease)
    else $error("release late outside idle");
  smbus_lps_a: assert property (smbusMode |=> !lpsEnable)
    else $error("low-power enable kept in sideband mode");
  pll_code_a: assert property (!$past(regWr) |-> $stable(pllLockCode))
    else $error("lock code moved without write");

  cover property (msgFail);
  cover property ($fell(txDataHold));
  cover property (ctrlTxReq && txIdleInd);
endmodule // ilc_chk

bind ilc_inband_lpi ilc_chk u_chk (.clk(clk), .sys_rst(sys_rst),
  .pwrGoodRst(pwrGoodRst), .regRd(regRd), .regWr(regWr),
  .regRdValid(regRdValid), .linkSpeed(linkSpeed), .linkUp(linkUp),
  .smbusMode(smbusMode), .lowPowerExit(lowPowerExit),
  .elecIdleReq(elecIdleReq), .ctrlTxReq(ctrlTxReq),
  .gigMsgInPacketOk(gigMsgInPacketOk), .txDataHold(txDataHold),
  .elecIdle(elecIdle), .txRelease(txRelease), .txIdleInd(txIdleInd),
  .gpio0Out(gpio0Out), .pllLockForce(pllLockForce),
  .pllLockCode(pllLockCode), .lpsEnable(lpsEnable), .msgFail(msgFail));
`default_nettype wire

// [dv/tb_ilc_inband_lpi.sv]
// Self-checking bench for the in-band link and idle control block.
// Assumes the controller model acknowledges messages at the far side.
`timescale 1ns/1ps
`default_nettype none
module tb_ilc_inband_lpi;
  localparam logic [9:0] PGL = ilc_pkg::PAGE_LINK;
  localparam logic [9:0] PGI = ilc_pkg::PAGE_IDLE;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        pwrGoodRst = 1'b1;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [9:0]  regPage = 10'h000;
  logic [4:0]  regAddr = 5'h00;
  logic [15:0] regWdata = 16'h0000;
  logic        smbusMode = 1'b0;
  logic        linkUp = 1'b0;
  logic [1:0]  linkSpeed = 2'h1;
  logic        linkLowPowerState = 1'b0;
  logic        mdioMsgReq = 1'b0;
  logic        lowPowerExit = 1'b0;
  logic        elecIdleReq = 1'b0;
  logic        ctrlTxReq = 1'b0;
  logic [1:0]  ackMode = 2'h1;
  logic [15:0] regRdata;
  logic [2:0]  pllLockCode;
  logic        regRdValid, msgAck, msgSend, msgIsMdio, msgFail;
  logic        gigMsgInPacketOk;
  logic        txDataHold, elecIdle, txRelease, txIdleInd, gpio0Out;
  logic        pllLockForce, lpsEnable;
  int          errors = 0;
  int          numChecks = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  ilc_inband_lpi DUT (.clk(clk), .sys_rst(sys_rst), .pwrGoodRst(pwrGoodRst),
    .regWr(regWr), .regRd(regRd), .regPage(regPage), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
    .smbusMode(smbusMode), .linkUp(linkUp), .linkSpeed(linkSpeed),
    .linkLowPowerState(linkLowPowerState), .mdioMsgReq(mdioMsgReq),
    .msgAck(msgAck), .msgSend(msgSend), .msgIsMdio(msgIsMdio),
    .msgFail(msgFail), .gigMsgInPacketOk(gigMsgInPacketOk),
    .lowPowerExit(lowPowerExit), .txDataHold(txDataHold),
    .elecIdleReq(elecIdleReq), .elecIdle(elecIdle), .ctrlTxReq(ctrlTxReq),
    .txRelease(txRelease), .txIdleInd(txIdleInd), .gpio0Out(gpio0Out),
    .pllLockForce(pllLockForce), .pllLockCode(pllLockCode),
    .lpsEnable(lpsEnable));

  ilc_ctrl_model PEER (.clk(clk), .sys_rst(sys_rst), .ackMode(ackMode),
    .msgSend(msgSend), .msgAck(msgAck));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Range check; a miss shows the count against the lower bound
  task automatic checkIn(input int n, input int lo, input int hi);
    check(16'(n), (n >= lo && n <= hi) ? 16'(n) : 16'(lo));
  endtask

  task automatic wr(input logic [9:0] pg, input logic [4:0] ad,
                    input logic [15:0] d);
    regPage <= pg;
    regAddr <= ad;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    // One idle edge so a following write raises the strobe again from low, never merging with this one
    @(posedge clk);
  endtask

  // Data and valid pulse follow the strobe edge; sampled mid-cycle
  task automatic rd(input logic [9:0] pg, input logic [4:0] ad,
                    input logic [15:0] exp);
    regPage <= pg;
    regAddr <= ad;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    check({15'h0000, regRdValid}, 16'h0001);
    check(regRdata, exp);
    @(posedge clk);
  endtask

  // Count falling edges until a level shows; bounded against hangs
  task automatic waitLvl(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 20000) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic exitLen(output int n);
    lowPowerExit <= 1'b1;
    @(posedge clk);
    lowPowerExit <= 1'b0;
    waitLvl(txDataHold, 1'b1, n);
    waitLvl(txDataHold, 1'b0, n);
    @(posedge clk);
  endtask

  task automatic t_regs();
    rd(PGL, 5'h12, 16'h0507);
    rd(PGL, 5'h14, 16'h5504);
    rd(PGL, 5'h15, 16'h0514);
    rd(PGL, 5'h17, 16'h0010);
    rd(PGI, 5'h14, 16'h0220);
    rd(PGL, 5'h11, 16'h0000);
    rd(PGI, 5'h1f, 16'h0000);
    wr(PGI, 5'h1f, 16'hffff);
    rd(PGI, 5'h1f, 16'h0000);
    wr(PGI, 5'h14, 16'h0f0f);
    rd(PGI, 5'h14, 16'h0f00);
    wr(PGL, 5'h15, 16'ha0c3);
    rd(PGL, 5'h15, 16'ha0c3);
    wr(PGI, 5'h14, 16'h0220);
    wr(PGL, 5'h15, 16'h0514);
  endtask

  task automatic t_resets();
    wr(PGI, 5'h12, 16'h0cc9);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(PGI, 5'h12, 16'h0cc9);
    pwrGoodRst <= 1'b1;
    repeat (2) @(posedge clk);
    pwrGoodRst <= 1'b0;
    @(posedge clk);
    rd(PGI, 5'h12, 16'h00c9);
  endtask

  task automatic t_link();
    wr(PGL, 5'h12, 16'h0587);
    wr(PGI, 5'h12, 16'h08c9);
    linkUp <= 1'b1;
    repeat (4) @(posedge clk);
    rd(PGI, 5'h14, 16'h6220);
    check({15'h0000, gigMsgInPacketOk}, 16'h0000);
    linkSpeed <= 2'h2;
    linkLowPowerState <= 1'b1;
    @(negedge clk);
    check({12'h000, pllLockForce, pllLockCode}, 16'h000a);
    check({14'h0000, txIdleInd, gigMsgInPacketOk}, 16'h0003);
    @(posedge clk);
    linkLowPowerState <= 1'b0;
    linkUp <= 1'b0;
    repeat (4) @(posedge clk);
    rd(PGI, 5'h14, 16'h0220);
    wr(PGI, 5'h12, 16'h00c9);
    linkUp <= 1'b1;
    wr(PGI, 5'h14, 16'h2220);
    linkUp <= 1'b0;
    repeat (4) @(posedge clk);
    rd(PGI, 5'h14, 16'h0220);
  endtask

  task automatic t_idle();
    int n;
    wr(PGI, 5'h14, 16'h1220);
    @(negedge clk);
    check({14'h0000, txIdleInd, gpio0Out}, 16'h0002);
    @(posedge clk);
    wr(PGI, 5'h12, 16'h04c9);
    ctrlTxReq <= 1'b1;
    @(posedge clk);
    ctrlTxReq <= 1'b0;
    check({15'h0000, gpio0Out}, 16'h0001);
    waitLvl(txRelease, 1'b1, n);
    checkIn(n, 600, 642);
    @(posedge clk);
    wr(PGI, 5'h14, 16'h0220);
    ctrlTxReq <= 1'b1;
    @(posedge clk);
    ctrlTxReq <= 1'b0;
    waitLvl(txRelease, 1'b1, n);
    checkIn(n, 1, 2);
    @(posedge clk);
    wr(PGI, 5'h12, 16'h00c9);
  endtask

  task automatic t_exit();
    int n;
    exitLen(n);
    checkIn(n, 80, 81);
    wr(PGL, 5'h15, 16'h0094);
    wr(PGL, 5'h11, 16'h4000);
    rd(PGL, 5'h11, 16'h4000);
    check({15'h0000, lpsEnable}, 16'h0001);
    smbusMode <= 1'b1;
    repeat (2) @(posedge clk);
    rd(PGL, 5'h11, 16'h0000);
    check({15'h0000, lpsEnable}, 16'h0000);
    exitLen(n);
    checkIn(n, 8000, 8001);
    smbusMode <= 1'b0;
    wr(PGL, 5'h15, 16'h0514);
    elecIdleReq <= 1'b1;
    @(posedge clk);
    elecIdleReq <= 1'b0;
    waitLvl(elecIdle, 1'b1, n);
    waitLvl(elecIdle, 1'b0, n);
    checkIn(n, 64, 66);
    @(posedge clk);
  endtask

  task automatic t_msg();
    int n, k = 0, t0 = 0, t1 = 0, tf = 0;
    waitLvl(msgSend, 1'b1, n);
    waitLvl(msgSend, 1'b0, n);
    waitLvl(msgSend, 1'b1, n);
    checkIn(n, 1960, 2040);
    @(posedge clk);
    ackMode <= 2'h2;
    wr(PGL, 5'h12, 16'h0502);
    mdioMsgReq <= 1'b1;
    @(posedge clk);
    mdioMsgReq <= 1'b0;
    for (int i = 0; i < 12000; i++) begin
      @(negedge clk);
      if (msgSend === 1'b1 && msgIsMdio === 1'b1) begin
        if (k == 0) t0 = i;
        t1 = i;
        k++;
      end
      if (msgFail === 1'b1 && k == 3 && tf == 0) tf = i;
    end
    checkIn(k, 3, 3);
    checkIn(tf - t1, 3400, 3480);
    checkIn(t1 - t0, 6800, 6960);
    @(posedge clk);
    ackMode <= 2'h0;
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    pwrGoodRst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_resets();
    t_link();
    t_idle();
    t_exit();
    t_msg();
    conclude();
  end

  // Watchdog; the tests need about 25k cycles, so 60k is ample
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule // tb_ilc_inband_lpi
`default_nettype wire
